// >>> hw/udic_flag_bit.sv
`timescale 1ns/1ps
module udic_flag_bit #(
   parameter logic RESET_VAL = 1'b0
) (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic reset,
   // causes
   input  wire logic hw_event,
   input  wire logic sw_force,
   input  wire logic sw_clear,
   // state
   output logic      pending
);
   logic next_pending;

   // set beats clear so a coincident event survives
   always_comb begin
      next_pending = pending;
      if (sw_clear)
         next_pending = 1'b0;
      if (hw_event || sw_force)
         next_pending = 1'b1;
   end

   always_ff @(posedge core_clk) begin
      if (reset)
         pending <= RESET_VAL;
      else
         pending <= next_pending;
   end
endmodule

// >>> hw/udic_frame_timer.sv
`timescale 1ns/1ps
module udic_frame_timer
   import udic_pkg::*;
#(
   parameter int FRAME_CYCLES = UDIC_FRAME_CYCLES
) (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic reset,
   // tick out
   output logic      frame_tick
);
   import udic_pkg::*;

   logic [15:0] count;
   logic [15:0] next_count;
   logic        next_frame_tick;

   always_comb begin
      next_frame_tick = 1'b0;
      next_count      = count + 16'h0001;
      if (count == 16'(FRAME_CYCLES - 1)) begin
         next_count      = 16'h0000;
         next_frame_tick = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         count      <= 16'h0000;
         frame_tick <= 1'b0;
      end else begin
         count      <= next_count;
         frame_tick <= next_frame_tick;
      end
   end
endmodule

// >>> hw/udic_top.sv
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// How it works
// [R01] a write of one to the clear word drops that pending flag
// [R02] the clear word stores nothing; it acts only at the write
// [R03] a write of one to the force word sets that pending flag
// [R04] the force word stores nothing readable; it acts only on flags
// [R05] bit 0 is the frame tick flag
// [R06] bits 1 to 8 are endpoints 0 to 7
// [R07] bit 9 is device status: bus reset, suspend or connect change
// [R08] bit 10 is command code empty
// [R09] bit 11 is command data full
// [R10] bit 12 is receive end of packet
// [R11] bit 13 is transmit end of packet
// [R12] enable bits reset to zero and gate each flag onto the request
// [R13] software writes zero to bits 31:14 and ignores their read value
// [R14] a disabled flag still latches and holds as pending
// [R15] frame tick flag rises once every millisecond
// [R16] after reset only command code empty reads pending
// [R17] a set in the same cycle as a clear leaves the flag pending
// [R18] request is the or of each flag anded with its enable
module udic_top
   import udic_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // hardware events, one-cycle pulses
   input  wire logic [7:0]  endpoint_event,
   input  wire logic        device_status_event,
   input  wire logic        command_code_empty_event,
   input  wire logic        command_data_full_event,
   input  wire logic        receive_end_of_packet_event,
   input  wire logic        transmit_end_of_packet_event,
   // interrupt request and flags
   output logic             usb_irq,
   output logic      [13:0] device_interrupt_status
);
   import udic_pkg::*;

   // ---------------------------------------------------------------
   // bus address phase capture
   // ---------------------------------------------------------------
   logic                     dph_write;
   logic                     dph_read;
   logic [UDIC_DEC_BITS-1:0] dph_addr;
   logic                     next_dph_write;
   logic                     next_dph_read;
   logic [UDIC_DEC_BITS-1:0] next_dph_addr;
   logic                     addr_ok;

   always_comb begin
      addr_ok        = hsel && hready && htrans[1];
      next_dph_write = addr_ok && hwrite;
      next_dph_read  = addr_ok && !hwrite;
      next_dph_addr  = addr_ok ? haddr[UDIC_DEC_BITS-1:0] : dph_addr;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         dph_write <= 1'b0;
         dph_read  <= 1'b0;
         dph_addr  <= '0;
      end else begin
         dph_write <= next_dph_write;
         dph_read  <= next_dph_read;
         dph_addr  <= next_dph_addr;
      end
   end

   // ---------------------------------------------------------------
   // write decode
   // ---------------------------------------------------------------
   logic                   wr_enable;
   logic [UDIC_NFLAGS-1:0] clr_mask;
   logic [UDIC_NFLAGS-1:0] force_mask;

   always_comb begin
      wr_enable = dph_write && (dph_addr == UDIC_ADDR_ENABLE[UDIC_DEC_BITS-1:0]);
      // [R01] [R02] clear strobe only
      clr_mask = (dph_write && (dph_addr == UDIC_ADDR_CLEAR[UDIC_DEC_BITS-1:0]))
               ? hwdata[UDIC_NFLAGS-1:0] : '0;
      // [R03] [R04] force strobe only
      force_mask = (dph_write && (dph_addr == UDIC_ADDR_FORCE[UDIC_DEC_BITS-1:0]))
                 ? hwdata[UDIC_NFLAGS-1:0] : '0;
   end

   // ---------------------------------------------------------------
   // enable register
   // ---------------------------------------------------------------
   logic [UDIC_NFLAGS-1:0] device_interrupt_enable;
   logic [UDIC_NFLAGS-1:0] next_enable;

   // [R12] enable write, upper bits dropped
   always_comb begin
      next_enable = wr_enable ? hwdata[UDIC_NFLAGS-1:0] : device_interrupt_enable;
   end

   always_ff @(posedge core_clk) begin
      if (reset)
         device_interrupt_enable <= UDIC_ENABLE_RESET;
      else
         device_interrupt_enable <= next_enable;
   end

   // ---------------------------------------------------------------
   // event sources
   // ---------------------------------------------------------------
   logic                   frame_tick;
   logic [UDIC_NFLAGS-1:0] hw_events;
   logic [UDIC_NFLAGS-1:0] flags;

   // [R15] millisecond tick
   udic_frame_timer #(
      .FRAME_CYCLES (UDIC_FRAME_CYCLES)
   ) u_frame (
      .core_clk   (core_clk),
      .reset      (reset),
      .frame_tick (frame_tick)
   );

   // [R05] [R06] [R07] [R08] [R09] [R10] [R11] bit placement
   always_comb begin
      hw_events = '0;
      hw_events[UDIC_BIT_FRAME]                    = frame_tick;
      hw_events[UDIC_BIT_EP0 +: UDIC_NEP]          = endpoint_event;
      hw_events[UDIC_BIT_DEVSTAT]                  = device_status_event;
      hw_events[UDIC_BIT_CCEMPTY]                  = command_code_empty_event;
      hw_events[UDIC_BIT_CDFULL]                   = command_data_full_event;
      hw_events[UDIC_BIT_RXEOP]                    = receive_end_of_packet_event;
      hw_events[UDIC_BIT_TXEOP]                    = transmit_end_of_packet_event;
   end

   // ---------------------------------------------------------------
   // pending flags
   // ---------------------------------------------------------------
   // [R14] [R16] [R17] flags latch regardless of enable
   for (genvar i = 0; i < UDIC_NFLAGS; i++) begin : g_flag
      udic_flag_bit #(
         .RESET_VAL (UDIC_STATUS_RESET[i])
      ) u_flag (
         .core_clk (core_clk),
         .reset    (reset),
         .hw_event (hw_events[i]),
         .sw_force (force_mask[i]),
         .sw_clear (clr_mask[i]),
         .pending  (flags[i])
      );
   end

   // ---------------------------------------------------------------
   // outputs and read data
   // ---------------------------------------------------------------
   logic [31:0] next_hrdata;
   logic        next_irq;

   always_comb begin
      next_hrdata = 32'h00000000;
      // reads of the write-only words return zero
      if (next_dph_read) begin
         if (haddr[UDIC_DEC_BITS-1:0] == UDIC_ADDR_STATUS[UDIC_DEC_BITS-1:0])
            next_hrdata = {18'h00000, flags};
         else if (haddr[UDIC_DEC_BITS-1:0] == UDIC_ADDR_ENABLE[UDIC_DEC_BITS-1:0])
            next_hrdata = {18'h00000, next_enable};
      end
      // [R18] gated or of all sources
      next_irq = |(flags & device_interrupt_enable);
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         hrdata                  <= 32'h00000000;
         usb_irq                 <= 1'b0;
         device_interrupt_status <= UDIC_STATUS_RESET;
         hreadyout               <= 1'b1;
         hresp                   <= 1'b0;
      end else begin
         hrdata                  <= next_hrdata;
         usb_irq                 <= next_irq;
         device_interrupt_status <= flags;
         hreadyout               <= 1'b1;
         hresp                   <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_clear_drops;
      @(posedge core_clk) disable iff (reset)
      (clr_mask[UDIC_BIT_EP0] && !force_mask[UDIC_BIT_EP0] && !endpoint_event[0])
         |=> !flags[UDIC_BIT_EP0];
   endproperty
   a_clear_drops: assert property (p_clear_drops) // [R01]
      else $error("clear write did not drop flag");

   property p_force_sets;
      @(posedge core_clk) disable iff (reset)
      force_mask[UDIC_BIT_TXEOP] |=> ##1 device_interrupt_status[UDIC_BIT_TXEOP];
   endproperty
   a_force_sets: assert property (p_force_sets) // [R03]
      else $error("force write did not set flag");

   property p_set_wins;
      @(posedge core_clk) disable iff (reset)
      (clr_mask[UDIC_BIT_CDFULL] && command_data_full_event) |=> flags[UDIC_BIT_CDFULL];
   endproperty
   a_set_wins: assert property (p_set_wins) // [R17]
      else $error("coincident event lost");

   property p_zero_keeps;
      @(posedge core_clk) disable iff (reset)
      (!clr_mask[UDIC_BIT_CCEMPTY] && !$past(reset)) |=>
         (flags[UDIC_BIT_CCEMPTY] || !$past(flags[UDIC_BIT_CCEMPTY]));
   endproperty
   a_zero_keeps: assert property (p_zero_keeps) // [R02]
      else $error("flag dropped without a clear");

   property p_irq_or;
      @(posedge core_clk) disable iff (reset)
      1'b1 |=> (usb_irq == |($past(flags) & $past(device_interrupt_enable)));
   endproperty
   a_irq_or: assert property (p_irq_or) // [R18]
      else $error("interrupt request mismatch");

   property p_masked_holds;
      @(posedge core_clk) disable iff (reset)
      (device_status_event && !device_interrupt_enable[UDIC_BIT_DEVSTAT]
         && !wr_enable) |=> ##1 (device_interrupt_status[UDIC_BIT_DEVSTAT]
         || $past(clr_mask[UDIC_BIT_DEVSTAT]));
   endproperty
   a_masked_holds: assert property (p_masked_holds) // [R14]
      else $error("disabled flag not latched");

   property p_frame_period;
      @(posedge core_clk) disable iff (reset)
      frame_tick |=> !frame_tick [*8];
   endproperty
   a_frame_period: assert property (p_frame_period) // [R15]
      else $error("frame tick too frequent");

   property p_reset_values;
      @(posedge core_clk)
      $past(reset) |-> (flags == UDIC_STATUS_RESET && device_interrupt_enable == '0);
   endproperty
   a_reset_values: assert property (p_reset_values) // [R16]
      else $error("reset values wrong");

   property p_enable_gate;
      @(posedge core_clk) disable iff (reset)
      (device_interrupt_enable == '0) |=> !usb_irq;
   endproperty
   a_enable_gate: assert property (p_enable_gate) // [R12]
      else $error("request raised with all sources disabled");

   property p_endpoint_map;
      @(posedge core_clk) disable iff (reset)
      endpoint_event[7] |=> flags[UDIC_BIT_EP0 + 7];
   endproperty
   a_endpoint_map: assert property (p_endpoint_map) // [R06]
      else $error("endpoint seven flag not set");
endmodule

// >>> include/udic_pkg.sv
package udic_pkg;

   // ---------------------------------------------------------------
   // register map (byte addresses, low bits decoded)
   // ---------------------------------------------------------------
   localparam logic [31:0] UDIC_ADDR_STATUS = 32'h40020000;
   localparam logic [31:0] UDIC_ADDR_ENABLE = 32'h40020004;
   localparam logic [31:0] UDIC_ADDR_CLEAR  = 32'h40020008;
   localparam logic [31:0] UDIC_ADDR_FORCE  = 32'h4002000C;
   localparam int          UDIC_DEC_BITS    = 8;

   // ---------------------------------------------------------------
   // flag layout
   // ---------------------------------------------------------------
   localparam int UDIC_NFLAGS      = 14;
   localparam int UDIC_NEP         = 8;
   localparam int UDIC_BIT_FRAME   = 0;
   localparam int UDIC_BIT_EP0     = 1;
   localparam int UDIC_BIT_DEVSTAT = 9;
   localparam int UDIC_BIT_CCEMPTY = 10;
   localparam int UDIC_BIT_CDFULL  = 11;
   localparam int UDIC_BIT_RXEOP   = 12;
   localparam int UDIC_BIT_TXEOP   = 13;

   localparam logic [13:0] UDIC_STATUS_RESET = 14'h0400;
   localparam logic [13:0] UDIC_ENABLE_RESET = 14'h0000;

   // ---------------------------------------------------------------
   // frame tick timing
   // ---------------------------------------------------------------
   localparam int UDIC_CLK_HZ       = 25000000;
   localparam int UDIC_FRAME_US     = 1000;
   localparam int UDIC_FRAME_CYCLES = UDIC_CLK_HZ / 1000000 * UDIC_FRAME_US;

   // ahb encodings
   localparam logic [1:0] UDIC_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] UDIC_HTRANS_SEQ    = 2'h3;

endpackage

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
   import udic_pkg::*;
   logic        core_clk, reset, hsel, hwrite, hready;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [1:0]  htrans, rsp;
   logic [2:0]  hsize;
   logic        hreadyout, hresp, usb_irq;
   logic [7:0]  endpoint_event;
   logic [4:0]  misc_event;
   logic [13:0] device_interrupt_status;
   int          fail_count, n_checks, cyc, t0;

   assign hready = hreadyout;

   udic_top dut (
      .core_clk                     (core_clk),
      .reset                        (reset),
      .hsel                         (hsel),
      .haddr                        (haddr),
      .htrans                       (htrans),
      .hwrite                       (hwrite),
      .hsize                        (hsize),
      .hwdata                       (hwdata),
      .hready                       (hready),
      .hrdata                       (hrdata),
      .hreadyout                    (hreadyout),
      .hresp                        (hresp),
      .endpoint_event               (endpoint_event),
      .device_status_event          (misc_event[0]),
      .command_code_empty_event     (misc_event[1]),
      .command_data_full_event      (misc_event[2]),
      .receive_end_of_packet_event  (misc_event[3]),
      .transmit_end_of_packet_event (misc_event[4]),
      .usb_irq                      (usb_irq),
      .device_interrupt_status      (device_interrupt_status)
   );

   initial core_clk = 1'b0;
   always #20 core_clk = ~core_clk;
   always @(posedge core_clk) cyc <= cyc + 1;

   // ---------------------------------------------------------------
   // checking and closing
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic results();
      if (fail_count == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // bus and event drivers
   // ---------------------------------------------------------------
   // evm rides the data phase so an event can meet a clear at one edge
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      input logic [13:0] evm);
      @(posedge core_clk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= UDIC_HTRANS_NONSEQ;
      hwrite <= wr;
      hsize  <= 3'h2;
      @(posedge core_clk);
      while (hready !== 1'b1) @(posedge core_clk);
      hsel           <= 1'b0;
      htrans         <= 2'h0;
      hwdata         <= wr ? d : 32'h0;
      endpoint_event <= evm[8:1];
      misc_event     <= evm[13:9];
      @(posedge core_clk);
      while (hready !== 1'b1) @(posedge core_clk);
      rdv = hrdata;
      rsp = {hresp, hreadyout};
      endpoint_event <= 8'h00;
      misc_event     <= 5'h00;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 14'h0000);
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, 14'h0000);
      check(rdv, exp);
      // zero wait states and an okay response on every read
      check({30'h0, rsp}, 32'h00000001);
   endtask

   // port copy of the flags lags the write by two edges
   task automatic st(input logic [13:0] exp);
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      check({18'h0, device_interrupt_status}, {18'h0, exp});
   endtask

   task automatic irq(input logic exp);
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      check({31'h0, usb_irq}, {31'h0, exp});
   endtask

   task automatic ev(input logic [13:0] m);
      @(posedge core_clk);
      endpoint_event <= m[8:1];
      misc_event     <= m[13:9];
      @(posedge core_clk);
      endpoint_event <= 8'h00;
      misc_event     <= 5'h00;
   endtask

   task automatic wait_frame();
      int n;
      n = 0;
      while (device_interrupt_status[0] !== 1'b1 && n < 26000) begin
         @(negedge core_clk);
         n++;
      end
   endtask

   // ---------------------------------------------------------------
   // watchdog and main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (70000) @(posedge core_clk);
      fail_count++;
      results();
   end

   initial begin
      cyc = 0; fail_count = 0; n_checks = 0;
      reset = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
      hsize = 3'h2; hwdata = 32'h0; endpoint_event = 8'h00; misc_event = 5'h00;
      repeat (3) @(posedge core_clk);
      reset <= 1'b0;
      st(UDIC_STATUS_RESET);
      irq(1'b0);
      rd(UDIC_ADDR_ENABLE, 32'h0);
      rd(UDIC_ADDR_STATUS, 32'h00000400);
      wr(UDIC_ADDR_FORCE, 32'h00000002);
      rd(UDIC_ADDR_FORCE, 32'h0);
      wr(UDIC_ADDR_CLEAR, 32'h00003FFF);
      rd(UDIC_ADDR_CLEAR, 32'h0);
      st(14'h0000);
      for (int i = 0; i < UDIC_NFLAGS; i++) begin
         wr(UDIC_ADDR_FORCE, 32'h1 << i);
         st(14'h1 << i);
         wr(UDIC_ADDR_CLEAR, 32'h1 << i);
         st(14'h0000);
         if (i > 0) begin
            ev(14'h1 << i);
            st(14'h1 << i);
            wr(UDIC_ADDR_CLEAR, 32'h00003FFF);
         end
      end
      wr(UDIC_ADDR_FORCE, 32'h00003FFF);
      wr(UDIC_ADDR_CLEAR, 32'h00001555);
      wr(UDIC_ADDR_FORCE, 32'h0);
      rd(UDIC_ADDR_STATUS, 32'h00002AAA);
      irq(1'b0);
      for (int i = 0; i < UDIC_NFLAGS; i++) begin
         wr(UDIC_ADDR_ENABLE, 32'h1 << i);
         irq((14'h2AAA >> i) & 14'h1);
      end
      wr(UDIC_ADDR_ENABLE, 32'h00003FFF);
      rd(UDIC_ADDR_ENABLE, 32'h00003FFF);
      wr(UDIC_ADDR_CLEAR, 32'h00003FFF);
      irq(1'b0);
      // event in the same edge as its own clear must survive
      bus(1'b1, UDIC_ADDR_CLEAR, 32'h00000824, 14'h0804);
      st(14'h0804);
      irq(1'b1);
      wr(UDIC_ADDR_STATUS + 32'h10, 32'h00003FFF);
      st(14'h0804);
      rd(UDIC_ADDR_STATUS + 32'h10, 32'h0);
      wr(UDIC_ADDR_CLEAR, 32'h00003FFF);
      wait_frame();
      t0 = cyc;
      check({31'h0, device_interrupt_status[0]}, 32'h1);
      wr(UDIC_ADDR_CLEAR, 32'h00000001);
      st(14'h0000);
      wait_frame();
      check(cyc - t0, UDIC_FRAME_CYCLES);
      results();
   end
endmodule
